/* lf_wakeup_correlator_control.sv */
// top of the wakeup correlator control: registers, channels, pin routing
`timescale 1ns/1ps
module lf_wakeup_correlator_control
  import lf_wakeup_pkg::*;
#(
  parameter int NCH   = 3,
  parameter int TICKS = TIMEOUT_TICKS
) (
  // clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  // register write port from the serial framing
  input  wire logic           regWrite,
  input  wire logic [1:0]     regAddr,
  input  wire logic [REG_W-1:0] regWdata,
  output logic [REG_W-1:0]    regRdata,
  // pins and oscillator
  input  wire logic           chipSelect,
  input  wire logic           oscTick,
  // analog-side inputs
  input  wire logic [NCH-1:0] sigDetect,
  input  wire logic [NCH-1:0] chanData,
  input  wire logic [NCH-1:0] patternMatch,
  input  wire logic [NCH-1:0] zeroErrors,
  // analog controls
  output logic [NCH-1:0]      amplifierOn,
  output logic [NCH-1:0]      correlatorClkEn,
  output logic                largeTauSel,
  output logic                highStepSel,
  output logic [1:0]          antennaRotation,
  output logic                inputsShorted,
  output logic                attenuatorOn,
  output logic [1:0]          zeroTolerance,
  // pins
  output logic                wakeOut_n,
  output logic                strengthOut,
  output logic                strengthOe,
  output logic [NCH-1:0]      chanWake
);
  //------------------------------------------------------------
  // register file
  //------------------------------------------------------------
  logic [REG_W-1:0] power_q, chsel_q, test_q, corr_q;

  // sleep does not gate the write port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_q <= POWER_RST;
      chsel_q <= CHSEL_RST;
      test_q  <= TEST_RST;
      corr_q  <= CORR_RST;
    end else if (regWrite) begin
      case (regAddr)
        ADDR_POWER: power_q <= regWdata;
        ADDR_CHSEL: chsel_q <= regWdata;
        ADDR_TEST:  test_q  <= regWdata;
        ADDR_CORR:  corr_q  <= regWdata;
        default:    corr_q  <= corr_q;
      endcase
    end
  end

  // read back for the controller
  always_comb begin
    case (regAddr)
      ADDR_POWER: regRdata = power_q;
      ADDR_CHSEL: regRdata = chsel_q;
      ADDR_TEST:  regRdata = test_q;
      default:    regRdata = corr_q;
    endcase
  end

  //------------------------------------------------------------
  // pin inputs
  //------------------------------------------------------------
  logic csSync;
  lf_sync2 #(.W(1)) lf_sync2_inst (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .asyncIn (chipSelect),
    .syncOut (csSync)
  );

  //------------------------------------------------------------
  // analog controls
  //------------------------------------------------------------
  logic rotBoth;
  assign rotBoth         = power_q[ROT_LO_BIT] & power_q[ROT_HI_BIT];
  assign antennaRotation = {power_q[ROT_HI_BIT], power_q[ROT_LO_BIT]};
  assign inputsShorted   = rotBoth;
  assign attenuatorOn    = chsel_q[ATTEN_BIT];
  assign largeTauSel     = corr_q[TAU_BIT];
  assign highStepSel     = test_q[STEP_BIT];
  // low bit first: 00->3, 10->2, 01->1, 11->0
  assign zeroTolerance   = 2'h3 - {corr_q[ZTOL_HI_BIT],
                                   corr_q[ZTOL_LO_BIT]};

  //------------------------------------------------------------
  // channels
  //------------------------------------------------------------
  logic [NCH-1:0] rxOn;
  logic [NCH-1:0] matchSeen_q;
  logic [NCH-1:0] wakeHold_q;
  logic [NCH-1:0] hit;
  logic           clearHold;

  assign clearHold = chsel_q[WCLR_BIT];

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      lf_channel_pm #(.TICKS(TICKS)) lf_channel_pm_inst (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .chanEnable  (power_q[CH_EN_LSB + g]),
        .oscTick     (oscTick),
        .sigDetect   (sigDetect[g]),
        .amplifierOn (amplifierOn[g]),
        .receiveOn   (rxOn[g])
      );
      // correlator clocks run only in receive and when not disabled
      assign correlatorClkEn[g] = rxOn[g] & ~corr_q[CORR_OFF_BIT];
      // a pattern counts only if its zero errors stay in tolerance
      assign hit[g] = correlatorClkEn[g] & patternMatch[g] &
                      ({1'b0, zeroErrors[g]} <= zeroTolerance);
    end
  endgenerate

  // first-pattern memory for double pattern mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      matchSeen_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        // a single-mode hit must not arm a later double-mode match
        if (!correlatorClkEn[i] || !corr_q[PAT_CNT_BIT])
          matchSeen_q[i] <= 1'b0;
        else if (hit[i]) matchSeen_q[i] <= ~matchSeen_q[i];
      end
    end
  end

  // sticky per-channel wake, cleared only while the clear bit is 1
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeHold_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (clearHold) wakeHold_q[i] <= 1'b0;
        else if (hit[i] && (!corr_q[PAT_CNT_BIT] || matchSeen_q[i]))
          wakeHold_q[i] <= 1'b1;
      end
    end
  end
  assign chanWake = wakeHold_q;

  // wake pin is active after power-on until cleared once
  logic porWake_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) porWake_q <= 1'b1;
    else if (clearHold) porWake_q <= 1'b0;
  end

  //------------------------------------------------------------
  // pin routing
  //------------------------------------------------------------
  logic [1:0] chSel;
  logic       selWake, selData, anyWake, combined;
  assign chSel    = {chsel_q[CHSEL_HI_BIT], chsel_q[CHSEL_LO_BIT]};
  assign anyWake  = (|wakeHold_q) | porWake_q;
  assign combined = (chSel == 2'h3);

  // low bit first: 00 ch1, 10 (low set) ch2, 01 (high set) ch3
  always_comb begin
    case (chSel)
      2'h0:    begin selWake = wakeHold_q[0]; selData = chanData[0]; end
      2'h1:    begin selWake = wakeHold_q[1]; selData = chanData[1]; end
      2'h2:    begin selWake = wakeHold_q[2]; selData = chanData[2]; end
      default: begin selWake = anyWake;       selData = 1'b0;        end
    endcase
  end

  logic wakeLvl_d, strLvl_d, strOe_d;
  logic testOn, tselWake, tselData, digMode;
  assign testOn   = test_q[TEN_BIT];
  assign tselWake = test_q[TSEL_LO_BIT] & ~test_q[TSEL_HI_BIT];
  assign tselData = ~test_q[TSEL_LO_BIT] & ~test_q[TSEL_HI_BIT];
  assign digMode  = chsel_q[OUTM_HI_BIT] & ~chsel_q[OUTM_LO_BIT];

  // wake pin level (active high here, inverted at the pin)
  always_comb begin
    if (clearHold) wakeLvl_d = 1'b0;
    else if (!testOn) wakeLvl_d = anyWake;
    else if (tselWake) wakeLvl_d = selWake;
    else if (tselData) wakeLvl_d = selData;
    else wakeLvl_d = 1'b0;
  end

  // strength pin: independent of the wake pin routing
  always_comb begin
    strOe_d = csSync & digMode;
    if (combined) strLvl_d = anyWake;
    else if (tselData) strLvl_d = selData;
    else strLvl_d = selWake;
  end

  // registered pin drivers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeOut_n   <= 1'b0;
      strengthOut <= 1'b0;
      strengthOe  <= 1'b0;
    end else begin
      wakeOut_n   <= ~wakeLvl_d;
      strengthOut <= strLvl_d;
      strengthOe  <= strOe_d;
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  // all three correlator clocks stop together while disabled
  a_corr_gated: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    corr_q[CORR_OFF_BIT] |-> correlatorClkEn == '0)
    else $error("correlator clock runs while disabled");

  // clear bit forces the wake pin high on the next edge
  a_clear_holds: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clearHold |=> wakeOut_n)
    else $error("wake pin not held high by clear");

  // strength pin released one edge after synchronised chip select drops
  a_cs_hiz: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !csSync |=> !strengthOe)
    else $error("strength pin driven without chip select");

  // outside clear and test mode, any sticky channel wake pulls the wake pin low
  a_or_wake: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (!clearHold && !testOn && (|wakeHold_q)) |=> !wakeOut_n)
    else $error("combined wake missing on wake pin");

  // single wake test mode with channel select 00 shows channel one
  a_single_wake: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (!clearHold && testOn && tselWake && chSel == 2'h0)
      |=> wakeOut_n == !$past(wakeHold_q[0]))
    else $error("wake pin not following channel one");

  // select 11 in digital mode copies the combined wake
  a_dig_combined: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (combined && digMode && csSync)
      |=> strengthOe && strengthOut == $past(anyWake))
    else $error("combined wake missing on strength pin");

  // digital mode, wake select: strength pin shows one channel
  a_dig_single: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (digMode && csSync && !combined && !tselData)
      |=> strengthOe && strengthOut == $past(selWake))
    else $error("strength pin not following selected wake");

  // one pattern is enough in single pattern mode
  a_single_pat: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (hit[0] && !corr_q[PAT_CNT_BIT] && !clearHold) |=> wakeHold_q[0])
    else $error("single pattern did not wake");

  // first of two patterns must not wake in double mode
  a_first_pat: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (hit[0] && corr_q[PAT_CNT_BIT] && !matchSeen_q[0] && !wakeHold_q[0])
      |=> !wakeHold_q[0])
    else $error("double pattern mode woke on first pattern");

  // tolerance code 11 accepts no invalid zero-half-bit
  a_tol_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (corr_q[ZTOL_LO_BIT] && corr_q[ZTOL_HI_BIT]) |-> zeroTolerance == 2'h0)
    else $error("tolerance code 11 not zero");

  // a pattern with too many zero errors is not a hit
  a_tol_reject: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (zeroTolerance == 2'h0 && zeroErrors[0]) |-> !hit[0])
    else $error("pattern accepted beyond zero tolerance");

  // sleep turns every amplifier off on the next edge
  a_sleep_off: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (power_q[CH_EN_LSB +: NCH] == '0) |=> amplifierOn == '0)
    else $error("amplifier left on in sleep");

  // correlator clocks never run outside receive
  a_rx_only: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (correlatorClkEn & ~rxOn) == '0)
    else $error("correlator clock runs outside receive");

  // data test mode puts the selected channel's data on the wake pin
  a_data_wake: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (!clearHold && testOn && tselData)
      |=> wakeOut_n == !$past(selData))
    else $error("wake pin not following channel data");

  // both rotation bits short the inputs, nothing else does
  a_short_both: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    inputsShorted == (antennaRotation == 2'h3))
    else $error("input short does not match rotation code");

  // damping resistor follows the attenuator bit
  a_atten_on: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    attenuatorOn == chsel_q[ATTEN_BIT])
    else $error("attenuator does not follow its bit");
endmodule : lf_wakeup_correlator_control

/* lf_wakeup_pkg.sv */
// constants and types shared by the wakeup correlator control block
//------------------------------------------------------------
// What this block does
// - Correlator-disable bit stops all three correlator clocks together.
// - Pattern-count bit: 0 needs one wake pattern, 1 needs two.
// - Zero-tolerance bits 00/10/01/11 allow 3/2/1/0 invalid zero-half-bits.
// - Time-constant bit: 0 small filter constant, 1 large constant.
// - Mode register resets with upper tolerance and time-constant bits set.
// - All channel enables 0 means sleep; register writes still accepted.
// - Standby: amplifier on, correlator off while no signal is seen.
// - Signal detected moves channel to receive; correlator scans there.
// - Receive returns to standby after about 3.3 ms without signal.
// - Strength step bit 0 selects reduced step, 1 the high step.
// - Rotation bits choose one of three rotated antenna orders.
// - Both rotation bits set shorts every channel's inputs.
// - Attenuator bit connects damping resistor across every channel.
// - Digital mode with channel select 11 puts combined wake on strength pin.
// - Strength pin driven only while chip select is 1.
// - Normally wake pin carries OR of the three channel wakes.
// - Test mode, select 10: wake pin carries selected channel's wake.
// - Digital mode drives strength pin with selected channel's signal.
// - Combined wake on wake pin and single wake on strength pin together.
// - Wake-clear 1 holds wake pin high; 0 re-arms, also after power-on.
// - Channel select 00/10/01 picks channel one/two/three; 11 combined.
// - Test-enable 0 gives normal wake; 1 gives the selected test signal.
//------------------------------------------------------------
package lf_wakeup_pkg;

  // register addresses on the two address bits
  localparam logic [1:0] ADDR_POWER = 2'h0;
  localparam logic [1:0] ADDR_CHSEL = 2'h1;
  localparam logic [1:0] ADDR_TEST  = 2'h2;
  localparam logic [1:0] ADDR_CORR  = 2'h3;

  localparam int REG_W = 6;

  // reset values
  localparam logic [5:0] POWER_RST = 6'h0F;
  localparam logic [5:0] CHSEL_RST = 6'h00;
  localparam logic [5:0] TEST_RST  = 6'h10;
  localparam logic [5:0] CORR_RST  = 6'h18;

  // correlator mode fields
  localparam int CORR_OFF_BIT  = 0;
  localparam int PAT_CNT_BIT   = 1;
  localparam int ZTOL_LO_BIT   = 2;
  localparam int ZTOL_HI_BIT   = 3;
  localparam int TAU_BIT       = 4;
  // power fields
  localparam int CH_EN_LSB     = 0;
  localparam int ROT_LO_BIT    = 4;
  localparam int ROT_HI_BIT    = 5;
  // channel select fields
  localparam int CHSEL_LO_BIT  = 0;
  localparam int CHSEL_HI_BIT  = 1;
  localparam int OUTM_LO_BIT   = 2;
  localparam int OUTM_HI_BIT   = 3;
  localparam int ATTEN_BIT     = 4;
  localparam int WCLR_BIT      = 5;
  // test fields
  localparam int TEN_BIT       = 0;
  localparam int TSEL_LO_BIT   = 1;
  localparam int TSEL_HI_BIT   = 2;
  localparam int STEP_BIT      = 4;

  // receive timeout
  localparam int OSC_HZ        = 32768;
  localparam int TIMEOUT_US    = 3300;
  localparam int TIMEOUT_TICKS = (TIMEOUT_US * OSC_HZ) / 1000000;
  localparam int TMR_W         = 8;

  typedef enum logic [1:0] {
    CH_OFF,
    CH_STANDBY,
    CH_RECEIVE
  } chan_state_type;

endpackage : lf_wakeup_pkg

/* lf_sync2.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module lf_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule : lf_sync2

/* lf_channel_pm.sv */
// per-channel sleep / standby / receive power state machine
`timescale 1ns/1ps
module lf_channel_pm
  import lf_wakeup_pkg::*;
#(
  parameter int TICKS = TIMEOUT_TICKS
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // control
  input  wire logic chanEnable,
  input  wire logic oscTick,
  input  wire logic sigDetect,
  // status
  output logic      amplifierOn,
  output logic      receiveOn
);
  localparam logic [TMR_W-1:0] TICKS_V = TMR_W'(TICKS);

  chan_state_type state_q;
  logic [TMR_W-1:0] tmr_q;

  // state transitions
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CH_OFF;
    end else begin
      case (state_q)
        CH_OFF: begin
          if (chanEnable) state_q <= CH_STANDBY;
        end
        CH_STANDBY: begin
          if (!chanEnable) state_q <= CH_OFF;
          else if (sigDetect) state_q <= CH_RECEIVE;
        end
        CH_RECEIVE: begin
          if (!chanEnable) state_q <= CH_OFF;
          else if (!sigDetect && oscTick && tmr_q >= TICKS_V)
            state_q <= CH_STANDBY;
        end
        default: state_q <= CH_OFF;
      endcase
    end
  end

  // silence timer in oscillator ticks; restarts on each detection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= '0;
    end else if (state_q != CH_RECEIVE || sigDetect) begin
      tmr_q <= '0;
    end else if (oscTick && tmr_q < TICKS_V) begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  assign amplifierOn = (state_q != CH_OFF);
  assign receiveOn   = (state_q == CH_RECEIVE);

  // silence timer never counts past the timeout
  a_timeout_bound: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    tmr_q <= TICKS_V)
    else $error("silence timer beyond timeout");
  // a tick with the timer at its limit ends receive
  a_timeout_exit: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (receiveOn && chanEnable && !sigDetect && oscTick && tmr_q == TICKS_V)
      |=> !receiveOn)
    else $error("receive kept after silence timeout");
  // no receive without a detected signal
  a_standby_no_rx: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == CH_STANDBY && !sigDetect && chanEnable) |=> !receiveOn)
    else $error("receive entered without signal");
  // a detected signal takes an enabled channel into receive
  a_detect_rx: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == CH_STANDBY && sigDetect && chanEnable) |=> receiveOn)
    else $error("receive not entered on detection");
endmodule : lf_channel_pm

/* lf_ctrl_model.sv */
// controller model: whole-register writes and readback on the write port
`timescale 1ns/1ps
module lf_ctrl_model
  import lf_wakeup_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // register port
  output logic                  regWrite,
  output logic [1:0]            regAddr,
  output logic [REG_W-1:0]      regWdata,
  input  wire logic [REG_W-1:0] regRdata
);
  //------------------------------------------------------------
  // idle levels
  //------------------------------------------------------------
  initial begin
    regWrite = 1'b0;
    regAddr  = 2'h0;
    regWdata = 6'h00;
  end

  // one write; data lines are scrambled once the write is taken
  task automatic wr(input logic [1:0] a, input logic [5:0] d);
    wait (rst_n);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= (a == ADDR_CORR) ? (d & 6'h1F) : d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    regWdata <= ~d;
  endtask : wr

  // readback is combinational, sampled once the address has settled
  task automatic rd(input logic [1:0] a, output logic [5:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    @(posedge ref_clk);
    #1 d = regRdata;
  endtask : rd

  // caller inspects the per-channel wakes before this runs
  task automatic rearm(input logic [5:0] keep);
    wr(ADDR_CHSEL, keep | 6'h20);
    wr(ADDR_CHSEL, keep);
  endtask : rearm
endmodule : lf_ctrl_model

/* lf_wakeup_correlator_control_tb_top.sv */
// self-checking testbench of the wakeup correlator control block
`timescale 1ns/1ps
module lf_wakeup_correlator_control_tb_top;
  import lf_wakeup_pkg::*;
  localparam int TK = 4;
  //------------------------------------------------------------
  // signals
  //------------------------------------------------------------
  logic             ref_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             regWrite;
  logic [1:0]       regAddr;
  logic [REG_W-1:0] regWdata, regRdata;
  logic             chipSelect = 1'b0, oscTick = 1'b0;
  logic [2:0]       sigDetect = 3'h0, chanData = 3'h0;
  logic [2:0]       patternMatch = 3'h0, zeroErrors = 3'h0;
  logic [2:0]       amplifierOn, correlatorClkEn, chanWake;
  logic             largeTauSel, highStepSel, inputsShorted, attenuatorOn;
  logic [1:0]       antennaRotation, zeroTolerance;
  logic             wakeOut_n, strengthOut, strengthOe;
  logic [5:0]       rv;
  int               errTotal = 0, numChecks = 0;

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  lf_wakeup_correlator_control #(.TICKS(TK)) lf_wakeup_correlator_control_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .chipSelect(chipSelect), .oscTick(oscTick), .sigDetect(sigDetect),
    .chanData(chanData), .patternMatch(patternMatch),
    .zeroErrors(zeroErrors), .amplifierOn(amplifierOn),
    .correlatorClkEn(correlatorClkEn), .largeTauSel(largeTauSel),
    .highStepSel(highStepSel), .antennaRotation(antennaRotation),
    .inputsShorted(inputsShorted), .attenuatorOn(attenuatorOn),
    .zeroTolerance(zeroTolerance), .wakeOut_n(wakeOut_n),
    .strengthOut(strengthOut), .strengthOe(strengthOe),
    .chanWake(chanWake));

  lf_ctrl_model lf_ctrl_model_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));

  //------------------------------------------------------------
  // shared helpers
  //------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // settle past the edge so registered pins have landed
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [1:0] a, input logic [5:0] d);
    lf_ctrl_model_inst.wr(a, d);
    tick(2);
  endtask : wr

  task automatic osc(input int n);
    repeat (n) begin
      @(posedge ref_clk) oscTick <= 1'b1;
      @(posedge ref_clk) oscTick <= 1'b0;
    end
    tick(1);
  endtask : osc

  task automatic match(input logic [2:0] ch);
    @(posedge ref_clk) patternMatch <= ch;
    @(posedge ref_clk) patternMatch <= 3'h0;
    tick(3);
  endtask : match

  task automatic finalReport();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finalReport

  //------------------------------------------------------------
  // scenarios
  //------------------------------------------------------------
  task automatic t_reset();
    logic [5:0] exp [4] = '{6'h0F, 6'h00, 6'h10, 6'h18};
    for (int a = 0; a < 4; a++) begin
      lf_ctrl_model_inst.rd(2'(a), rv);
      check(8'(rv), 8'(exp[a]));
    end
    check(8'(largeTauSel), 8'h01);
    check(8'(zeroTolerance), 8'h01);
    check(8'(highStepSel), 8'h01);
    check(8'(wakeOut_n), 8'h00);
    check(8'(strengthOe), 8'h00);
  endtask : t_reset

  task automatic t_corr();
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CORR, 6'h10 | 6'(m << 2));
      check(8'(zeroTolerance), 8'(3 - m));
    end
    wr(ADDR_CORR, 6'h00);
    check(8'(largeTauSel), 8'h00);
    wr(ADDR_CORR, 6'h18);
    check(8'(largeTauSel), 8'h01);
  endtask : t_corr

  task automatic t_power();
    wr(ADDR_POWER, 6'h09);
    check(8'(amplifierOn), 8'h01);
    check(8'(correlatorClkEn), 8'h00);
    @(posedge ref_clk) sigDetect <= 3'h1;
    tick(3);
    check(8'(correlatorClkEn), 8'h01);
    wr(ADDR_CORR, 6'h19);
    check(8'(correlatorClkEn), 8'h00);
    wr(ADDR_CORR, 6'h18);
    @(posedge ref_clk) sigDetect <= 3'h0;
    osc(TK - 1);
    @(posedge ref_clk) sigDetect <= 3'h1;
    @(posedge ref_clk) sigDetect <= 3'h0;
    osc(TK);
    check(8'(correlatorClkEn), 8'h01);
    osc(1);
    check(8'(correlatorClkEn), 8'h00);
    check(8'(amplifierOn), 8'h01);
    wr(ADDR_POWER, 6'h00);
    check(8'(amplifierOn), 8'h00);
    wr(ADDR_POWER, 6'h0F);
    lf_ctrl_model_inst.rd(ADDR_POWER, rv);
    check(8'(rv), 8'h0F);
  endtask : t_power

  task automatic t_pins();
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_POWER, {2'(r), 4'hF});
      check(8'(antennaRotation), 8'(r));
      check(8'(inputsShorted), 8'(r == 3));
    end
    wr(ADDR_POWER, 6'h0F);
    wr(ADDR_CHSEL, 6'h10);
    check(8'(attenuatorOn), 8'h01);
    wr(ADDR_CHSEL, 6'h00);
    check(8'(attenuatorOn), 8'h00);
    wr(ADDR_TEST, 6'h00);
    check(8'(highStepSel), 8'h00);
    wr(ADDR_TEST, 6'h10);
    check(8'(highStepSel), 8'h01);
  endtask : t_pins

  task automatic t_wake();
    @(posedge ref_clk) sigDetect <= 3'h7;
    lf_ctrl_model_inst.rearm(6'h00);
    tick(2);
    check(8'(wakeOut_n), 8'h01);
    match(3'h2);
    check(8'(wakeOut_n), 8'h00);
    check(8'(chanWake), 8'h02);
    // wake select on the strength pin, normal wake on the wake pin
    @(posedge ref_clk) chipSelect <= 1'b1;
    wr(ADDR_TEST, 6'h12);
    wr(ADDR_CHSEL, 6'h09);
    tick(4);
    check(8'(strengthOe), 8'h01);
    check(8'(strengthOut), 8'h01);
    check(8'(wakeOut_n), 8'h00);
    wr(ADDR_CHSEL, 6'h08);
    check(8'(strengthOut), 8'h00);
    wr(ADDR_CHSEL, 6'h0B);
    check(8'(strengthOut), 8'h01);
    // data select: channel three data on both pins
    wr(ADDR_TEST, 6'h11);
    @(posedge ref_clk) chanData <= 3'h4;
    wr(ADDR_CHSEL, 6'h0A);
    check(8'(strengthOut), 8'h01);
    check(8'(wakeOut_n), 8'h00);
    @(posedge ref_clk) chanData <= 3'h0;
    tick(2);
    check(8'(strengthOut), 8'h00);
    check(8'(wakeOut_n), 8'h01);
    @(posedge ref_clk) chipSelect <= 1'b0;
    tick(5);
    check(8'(strengthOe), 8'h00);
    wr(ADDR_TEST, 6'h13);
    wr(ADDR_CHSEL, 6'h01);
    check(8'(wakeOut_n), 8'h00);
    wr(ADDR_CHSEL, 6'h00);
    check(8'(wakeOut_n), 8'h01);
    wr(ADDR_CHSEL, 6'h02);
    check(8'(wakeOut_n), 8'h01);
    wr(ADDR_TEST, 6'h10);
    check(8'(wakeOut_n), 8'h00);
    lf_ctrl_model_inst.rearm(6'h00);
    tick(2);
    check(8'(wakeOut_n), 8'h01);
    wr(ADDR_CORR, 6'h1A);
    match(3'h1);
    check(8'(wakeOut_n), 8'h01);
    match(3'h1);
    check(8'(wakeOut_n), 8'h00);
    // one invalid zero-half-bit: refused at code 11, taken at code 01
    lf_ctrl_model_inst.rearm(6'h00);
    wr(ADDR_CORR, 6'h1C);
    @(posedge ref_clk) zeroErrors <= 3'h1;
    match(3'h1);
    check(8'(chanWake), 8'h00);
    wr(ADDR_CORR, 6'h18);
    match(3'h1);
    check(8'(chanWake), 8'h01);
  endtask : t_wake

  //------------------------------------------------------------
  // main sequence and watchdog
  //------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_corr();
    t_power();
    t_pins();
    t_wake();
    finalReport();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    errTotal++;
    finalReport();
  end
endmodule : lf_wakeup_correlator_control_tb_top
